// *** rct_cal_timer.sv ***
// Filter calibration timer: runs for 560 * (duration + 4) clock cycles.
// Assumes start comes from logic on the same clock and duration is registered.
`timescale 1ns/1ps
`default_nettype none
module rct_cal_timer #(
  parameter int unsigned UNIT_CYCLES = rct_pkg::CAL_UNIT_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [3:0] duration,
  output logic busy,
  output logic done
);

  rct_pkg::rct_timer_t t_reg;
  rct_pkg::rct_timer_t t_next;

  // Counting units then steps avoids a multiplier for the long count.
  always_comb begin
    t_next = t_reg;
    t_next.done = 1'b0;
    if (!t_reg.busy) begin
      if (start) begin
        t_next.busy = 1'b1;
        t_next.unit_cnt = 16'h0000;
        t_next.dur_l = duration;
        t_next.steps = 5'(duration) + 5'(rct_pkg::CAL_STEP_OFFSET);
        t_next.elapsed = 16'h0000;
      end
    end else begin
      t_next.elapsed = t_reg.elapsed + 16'h0001;
      if (t_reg.unit_cnt == 16'(UNIT_CYCLES - 1)) begin
        t_next.unit_cnt = 16'h0000;
        t_next.steps = t_reg.steps - 5'h01;
        if (t_reg.steps == 5'h01) begin
          t_next.busy = 1'b0;
          t_next.done = 1'b1;
        end
      end else begin
        t_next.unit_cnt = t_reg.unit_cnt + 16'h0001;
      end
    end
    if (!rst_n) begin
      t_next = '0;
    end
  end

  always_ff @(posedge clock) begin
    t_reg <= t_next;
  end

  assign busy = t_reg.busy;
  assign done = t_reg.done;

  a_cal_done_time: assert property (
    @(posedge clock) disable iff (!rst_n)
    t_reg.done |-> t_reg.elapsed ==
      16'(UNIT_CYCLES * (32'(t_reg.dur_l) + rct_pkg::CAL_STEP_OFFSET)))
    else $error("Calibration time does not match the duration field.");

  a_cal_start_taken: assert property (
    @(posedge clock) disable iff (!rst_n)
    (!t_reg.busy && start) |=> (t_reg.busy && t_reg.dur_l == $past(duration)))
    else $error("Calibration start was not taken.");

endmodule
`default_nettype wire

// *** rct_pkg.sv ***
// Package for the receiver calibration and trim register bank.
// Assumes one 50 MHz clock that also serves as the crystal reference period.
package rct_pkg;

  localparam int CLK_PERIOD_NS = 20;
  localparam int ADDR_W = 12;

  // Register indexes; the byte address is four times the index.
  localparam logic [7:0] IDX_CAL_TIME = 8'h8A;
  localparam logic [7:0] IDX_CAL_BW = 8'h8B;
  localparam logic [7:0] IDX_COARSE = 8'h8C;
  localparam logic [7:0] IDX_FINE = 8'h8D;
  localparam logic [7:0] IDX_BUF_CFG = 8'h8E;
  localparam logic [7:0] IDX_SRC_SEL = 8'h8F;

  // Values after reset.
  localparam logic [7:0] RST_CAL_TIME = 8'h07;
  localparam logic [7:0] RST_CAL_BW = 8'h04;
  localparam logic [7:0] RST_COARSE = 8'h10;
  localparam logic [7:0] RST_FINE = 8'h00;
  localparam logic [7:0] RST_BUF_CFG = 8'h01;
  localparam logic [7:0] RST_SRC_SEL = 8'h00;

  // Field positions.
  localparam int BUF_EN_BIT = 0;

  // Calibration time is crystal period * 80 * 7 * (field + 4).
  localparam int CAL_XTAL_MULT_A = 80;
  localparam int CAL_XTAL_MULT_B = 7;
  localparam int CAL_STEP_OFFSET = 4;
  localparam int CAL_UNIT_CYCLES = CAL_XTAL_MULT_A * CAL_XTAL_MULT_B;

  localparam logic [4:0] COARSE_MAX = 5'h18;

  localparam logic [5:0] BW_50K = 6'h04;
  localparam logic [5:0] BW_80K = 6'h0D;
  localparam logic [5:0] BW_125K = 6'h16;
  localparam logic [5:0] BW_200K = 6'h1F;
  localparam logic [5:0] BW_300K = 6'h27;

  localparam logic [2:0] SRC_LEVEL = 3'h0;
  localparam logic [2:0] SRC_TEMP = 3'h1;
  localparam logic [2:0] SRC_SUPPLY_HALF = 3'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Internal register selector codes.
  localparam logic [2:0] SEL_CAL_TIME = 3'h0;
  localparam logic [2:0] SEL_CAL_BW = 3'h1;
  localparam logic [2:0] SEL_COARSE = 3'h2;
  localparam logic [2:0] SEL_FINE = 3'h3;
  localparam logic [2:0] SEL_BUF_CFG = 3'h4;
  localparam logic [2:0] SEL_SRC_SEL = 3'h5;
  localparam logic [2:0] SEL_NONE = 3'h7;

  typedef enum logic [1:0] {
    WS_IDLE = 2'h0,
    WS_ADDR = 2'h1,
    WS_RESP = 2'h3,
    WS_DATA = 2'h2
  } rct_wr_state_t;

  typedef struct packed {
    rct_wr_state_t wst;
    logic aw_rdy;
    logic w_rdy;
    logic [11:0] waddr;
    logic [7:0] wdata;
    logic wen;
    logic [1:0] bresp;
    logic bvalid;
    logic ar_rdy;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [3:0] cal_time;
    logic [5:0] cal_bw;
    logic [4:0] coarse;
    logic [3:0] fine;
    logic buf_en;
    logic [2:0] src;
    logic [3:0] o_dur;
    logic [5:0] o_bw;
    logic [4:0] o_coarse;
    logic [3:0] o_fine;
    logic o_buf;
    logic [2:0] o_route;
  } rct_state_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic [15:0] unit_cnt;
    logic [4:0] steps;
    logic [3:0] dur_l;
    logic [15:0] elapsed;
  } rct_timer_t;

endpackage

// *** rct_trim_regs.sv ***
// Receiver calibration and trim register bank behind an AXI4-Lite slave.
// Assumes a 50 MHz clock that is also the crystal reference, and a master
// that keeps one write and one read in flight at most.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module rct_trim_regs #(
  parameter int unsigned CAL_UNIT_CYCLES = rct_pkg::CAL_UNIT_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic CAL_START,
  output logic CAL_BUSY,
  output logic CAL_DONE,
  output logic [5:0] FILTER_CAL_BANDWIDTH,
  output logic [4:0] CRYSTAL_COARSE_CAP,
  output logic CRYSTAL_FINE_CAP_500F,
  output logic CRYSTAL_FINE_CAP_250F,
  output logic CRYSTAL_FINE_CAP_125F,
  output logic CRYSTAL_FINE_CAP_62F,
  output logic LEVEL_PIN_BUFFER_EN,
  output logic CONVERTER_ROUTE_LEVEL,
  output logic CONVERTER_ROUTE_TEMP,
  output logic CONVERTER_ROUTE_SUPPLY_HALF
);

  rct_pkg::rct_state_t s_reg;
  rct_pkg::rct_state_t s_next;

  logic wr_fire;
  logic wr_en;
  logic [2:0] wr_sel;
  logic [7:0] wr_data;

  // Misaligned or unknown addresses decode to no register.
  function automatic logic [2:0] reg_sel(input logic [11:0] addr);
    logic [9:0] idx;
    idx = addr[11:2];
    if (addr[1:0] != 2'h0) begin
      reg_sel = rct_pkg::SEL_NONE;
    end else if (idx == 10'(rct_pkg::IDX_CAL_TIME)) begin
      reg_sel = rct_pkg::SEL_CAL_TIME;
    end else if (idx == 10'(rct_pkg::IDX_CAL_BW)) begin
      reg_sel = rct_pkg::SEL_CAL_BW;
    end else if (idx == 10'(rct_pkg::IDX_COARSE)) begin
      reg_sel = rct_pkg::SEL_COARSE;
    end else if (idx == 10'(rct_pkg::IDX_FINE)) begin
      reg_sel = rct_pkg::SEL_FINE;
    end else if (idx == 10'(rct_pkg::IDX_BUF_CFG)) begin
      reg_sel = rct_pkg::SEL_BUF_CFG;
    end else if (idx == 10'(rct_pkg::IDX_SRC_SEL)) begin
      reg_sel = rct_pkg::SEL_SRC_SEL;
    end else begin
      reg_sel = rct_pkg::SEL_NONE;
    end
  endfunction

  // The stored code is kept as written; only the capacitor drive saturates.
  function automatic logic [4:0] sat_coarse(input logic [4:0] code);
    if (code > rct_pkg::COARSE_MAX) begin
      sat_coarse = rct_pkg::COARSE_MAX;
    end else begin
      sat_coarse = code;
    end
  endfunction

  // Unused source codes leave every converter input switch open.
  function automatic logic [2:0] route(input logic [2:0] src);
    case (src)
      rct_pkg::SRC_LEVEL: route = 3'h1;
      rct_pkg::SRC_TEMP: route = 3'h2;
      rct_pkg::SRC_SUPPLY_HALF: route = 3'h4;
      default: route = 3'h0;
    endcase
  endfunction

  always_comb begin
    logic aw_hs;
    logic w_hs;
    logic [2:0] rsel;
    logic [11:0] wa;
    aw_hs = S_AXI_AWVALID && s_reg.aw_rdy;
    w_hs = S_AXI_WVALID && s_reg.w_rdy;
    rsel = reg_sel(S_AXI_ARADDR);
    wa = s_reg.waddr;
    wr_fire = 1'b0;
    wr_data = s_reg.wdata;
    wr_en = s_reg.wen;
    s_next = s_reg;

    // Address and data are captured in either order.
    if (aw_hs) begin
      wa = S_AXI_AWADDR;
    end
    if (w_hs) begin
      wr_data = S_AXI_WDATA[7:0];
      wr_en = S_AXI_WSTRB[0];
    end
    wr_sel = reg_sel(wa);
    s_next.waddr = wa;
    s_next.wdata = wr_data;
    s_next.wen = wr_en;

    case (s_reg.wst)
      rct_pkg::WS_IDLE: begin
        if (aw_hs && w_hs) begin
          wr_fire = 1'b1;
          s_next.wst = rct_pkg::WS_RESP;
        end else if (aw_hs) begin
          s_next.wst = rct_pkg::WS_ADDR;
        end else if (w_hs) begin
          s_next.wst = rct_pkg::WS_DATA;
        end
      end
      rct_pkg::WS_ADDR: begin
        if (w_hs) begin
          wr_fire = 1'b1;
          s_next.wst = rct_pkg::WS_RESP;
        end
      end
      rct_pkg::WS_DATA: begin
        if (aw_hs) begin
          wr_fire = 1'b1;
          s_next.wst = rct_pkg::WS_RESP;
        end
      end
      rct_pkg::WS_RESP: begin
        if (S_AXI_BREADY) begin
          s_next.wst = rct_pkg::WS_IDLE;
        end
      end
      default: begin
        s_next.wst = rct_pkg::WS_IDLE;
      end
    endcase

    s_next.aw_rdy = (s_next.wst == rct_pkg::WS_IDLE) || (s_next.wst == rct_pkg::WS_DATA);
    s_next.w_rdy = (s_next.wst == rct_pkg::WS_IDLE) || (s_next.wst == rct_pkg::WS_ADDR);
    s_next.bvalid = (s_next.wst == rct_pkg::WS_RESP);

    // Only the defined field bits are stored, so unused bits drop writes.
    if (wr_fire) begin
      s_next.bresp = (wr_sel == rct_pkg::SEL_NONE) ? rct_pkg::RESP_SLVERR : rct_pkg::RESP_OKAY;
      if (wr_en) begin
        case (wr_sel)
          rct_pkg::SEL_CAL_TIME: s_next.cal_time = wr_data[3:0];
          rct_pkg::SEL_CAL_BW: s_next.cal_bw = wr_data[5:0];
          rct_pkg::SEL_COARSE: s_next.coarse = wr_data[4:0];
          rct_pkg::SEL_FINE: s_next.fine = wr_data[3:0];
          rct_pkg::SEL_BUF_CFG: s_next.buf_en = wr_data[rct_pkg::BUF_EN_BIT];
          rct_pkg::SEL_SRC_SEL: s_next.src = wr_data[2:0];
          default: s_next.bresp = rct_pkg::RESP_SLVERR;
        endcase
      end
    end

    // Read channel: one read at a time, answered one cycle after the address.
    if (S_AXI_ARVALID && s_reg.ar_rdy) begin
      s_next.ar_rdy = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rresp = rct_pkg::RESP_OKAY;
      case (rsel)
        rct_pkg::SEL_CAL_TIME: s_next.rdata = {4'h0, s_reg.cal_time};
        rct_pkg::SEL_CAL_BW: s_next.rdata = {2'h0, s_reg.cal_bw};
        rct_pkg::SEL_COARSE: s_next.rdata = {3'h0, s_reg.coarse};
        rct_pkg::SEL_FINE: s_next.rdata = {4'h0, s_reg.fine};
        rct_pkg::SEL_BUF_CFG: s_next.rdata = {7'h00, s_reg.buf_en};
        rct_pkg::SEL_SRC_SEL: s_next.rdata = {5'h00, s_reg.src};
        default: begin
          s_next.rdata = 8'h00;
          s_next.rresp = rct_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_reg.rvalid && S_AXI_RREADY) begin
      s_next.rvalid = 1'b0;
      s_next.ar_rdy = 1'b1;
    end

    // Drive points lag the register by one clock so they change glitch free.
    s_next.o_dur = s_reg.cal_time;
    s_next.o_bw = s_reg.cal_bw;
    s_next.o_coarse = sat_coarse(s_reg.coarse);
    s_next.o_fine = s_reg.fine;
    s_next.o_buf = s_reg.buf_en;
    s_next.o_route = route(s_reg.src);

    if (!RST_N) begin
      s_next = '0;
      s_next.wst = rct_pkg::WS_IDLE;
      s_next.aw_rdy = 1'b1;
      s_next.w_rdy = 1'b1;
      s_next.ar_rdy = 1'b1;
      s_next.cal_time = rct_pkg::RST_CAL_TIME[3:0];
      s_next.cal_bw = rct_pkg::RST_CAL_BW[5:0];
      s_next.coarse = rct_pkg::RST_COARSE[4:0];
      s_next.fine = rct_pkg::RST_FINE[3:0];
      s_next.buf_en = rct_pkg::RST_BUF_CFG[rct_pkg::BUF_EN_BIT];
      s_next.src = rct_pkg::RST_SRC_SEL[2:0];
      s_next.o_dur = rct_pkg::RST_CAL_TIME[3:0];
      s_next.o_bw = rct_pkg::RST_CAL_BW[5:0];
      s_next.o_coarse = sat_coarse(rct_pkg::RST_COARSE[4:0]);
      s_next.o_fine = rct_pkg::RST_FINE[3:0];
      s_next.o_buf = rct_pkg::RST_BUF_CFG[rct_pkg::BUF_EN_BIT];
      s_next.o_route = route(rct_pkg::RST_SRC_SEL[2:0]);
    end
  end

  always_ff @(posedge CLOCK) begin
    s_reg <= s_next;
  end

  rct_cal_timer #(
    .UNIT_CYCLES(CAL_UNIT_CYCLES)
  ) u_cal_timer (
    .clock(CLOCK),
    .rst_n(RST_N),
    .start(CAL_START),
    .duration(s_reg.o_dur),
    .busy(CAL_BUSY),
    .done(CAL_DONE)
  );

  assign S_AXI_AWREADY = s_reg.aw_rdy;
  assign S_AXI_WREADY = s_reg.w_rdy;
  assign S_AXI_BVALID = s_reg.bvalid;
  assign S_AXI_BRESP = s_reg.bresp;
  assign S_AXI_ARREADY = s_reg.ar_rdy;
  assign S_AXI_RVALID = s_reg.rvalid;
  assign S_AXI_RRESP = s_reg.rresp;
  assign S_AXI_RDATA = {24'h000000, s_reg.rdata};
  assign FILTER_CAL_BANDWIDTH = s_reg.o_bw;
  assign CRYSTAL_COARSE_CAP = s_reg.o_coarse;
  assign CRYSTAL_FINE_CAP_500F = s_reg.o_fine[3];
  assign CRYSTAL_FINE_CAP_250F = s_reg.o_fine[2];
  assign CRYSTAL_FINE_CAP_125F = s_reg.o_fine[1];
  assign CRYSTAL_FINE_CAP_62F = s_reg.o_fine[0];
  assign LEVEL_PIN_BUFFER_EN = s_reg.o_buf;
  assign CONVERTER_ROUTE_LEVEL = s_reg.o_route[0];
  assign CONVERTER_ROUTE_TEMP = s_reg.o_route[1];
  assign CONVERTER_ROUTE_SUPPLY_HALF = s_reg.o_route[2];

  a_bw_write_reach: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (wr_fire && wr_en && wr_sel == rct_pkg::SEL_CAL_BW) |->
      ##2 ({2'h0, FILTER_CAL_BANDWIDTH} == ($past(wr_data, 2) & 8'h3F)))
    else $error("Bandwidth code did not reach its output two clocks after the write.");

  a_coarse_write_reach: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (wr_fire && wr_en && wr_sel == rct_pkg::SEL_COARSE && wr_data[4:0] <= rct_pkg::COARSE_MAX)
      |-> ##2 ({3'h0, CRYSTAL_COARSE_CAP} == ($past(wr_data, 2) & 8'h1F)))
    else $error("Coarse trim code did not reach the capacitor drive.");

  a_coarse_saturates: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (s_reg.coarse > rct_pkg::COARSE_MAX) |=> (CRYSTAL_COARSE_CAP == rct_pkg::COARSE_MAX))
    else $error("Coarse trim drive went beyond its maximum.");

  a_fine_write_reach: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (wr_fire && wr_en && wr_sel == rct_pkg::SEL_FINE) |-> ##2
      ({4'h0, CRYSTAL_FINE_CAP_500F, CRYSTAL_FINE_CAP_250F, CRYSTAL_FINE_CAP_125F,
        CRYSTAL_FINE_CAP_62F} == ($past(wr_data, 2) & 8'h0F)))
    else $error("Fine trim bits did not reach their capacitors.");

  a_buffer_reset_on: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    $rose(RST_N) |-> (LEVEL_PIN_BUFFER_EN ##1 LEVEL_PIN_BUFFER_EN))
    else $error("Level pin buffer is not enabled after reset.");

  a_route_exclusive: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    $onehot0({CONVERTER_ROUTE_LEVEL, CONVERTER_ROUTE_TEMP, CONVERTER_ROUTE_SUPPLY_HALF}))
    else $error("More than one converter input is routed.");

  a_route_follows: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (s_reg.src == rct_pkg::SRC_SUPPLY_HALF) |=> CONVERTER_ROUTE_SUPPLY_HALF)
    else $error("Half supply was not routed for its code.");

  a_read_upper_zero: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    S_AXI_RVALID |-> (S_AXI_RDATA[31:8] == 24'h000000))
    else $error("Upper read data bits are not zero.");

  a_write_answer: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    wr_fire |=> (S_AXI_BVALID && !S_AXI_AWREADY && !S_AXI_WREADY))
    else $error("Write was not answered one clock after completion.");

  a_resp_holds: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (S_AXI_RVALID && !S_AXI_RREADY) |=> (S_AXI_RVALID && $stable(S_AXI_RDATA)))
    else $error("Read answer dropped before it was taken.");

  a_time_write_reach: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (wr_fire && wr_en && wr_sel == rct_pkg::SEL_CAL_TIME) |->
      ##2 (s_reg.o_dur == $past(wr_data[3:0], 2)))
    else $error("Calibration duration did not reach the timer two clocks after the write.");

  a_refused_write_keeps: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (wr_fire && (!wr_en || wr_sel == rct_pkg::SEL_NONE)) |=>
      $stable({s_reg.cal_time, s_reg.cal_bw, s_reg.coarse,
        s_reg.fine, s_reg.buf_en, s_reg.src}))
    else $error("A refused write changed a register.");

  a_error_resp_write: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (wr_fire && wr_sel == rct_pkg::SEL_NONE) |=>
      (S_AXI_BVALID && S_AXI_BRESP == rct_pkg::RESP_SLVERR))
    else $error("Unmapped write was not refused with an error response.");

  a_buffer_follows: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    1'b1 |=> (LEVEL_PIN_BUFFER_EN == $past(s_reg.buf_en)))
    else $error("Level pin buffer enable did not follow its register bit.");

endmodule
`default_nettype wire

// *** rct_trim_regs_bench.sv ***
// Self-checking bench for the receiver calibration and trim register bank.
// Assumes the bank answers over AXI4-Lite and runs its timer with four-cycle units.
`timescale 1ns/1ps
`default_nettype none
module rct_trim_regs_bench;
  localparam int unsigned UNIT = 4;
  localparam logic [7:0] IDX [6] = '{8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h8F};
  localparam logic [7:0] RSTV [6] = '{8'h07, 8'h04, 8'h10, 8'h00, 8'h01, 8'h00};
  localparam logic [7:0] MASK [6] = '{8'h0F, 8'h3F, 8'h1F, 8'h0F, 8'h01, 8'h07};
  localparam logic [5:0] BWS [5] = '{6'h04, 6'h0D, 6'h16, 6'h1F, 6'h27};
  logic clock;
  logic rst_n = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic cal_start = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, cal_busy, cal_done, buf_en;
  logic r_level, r_temp, r_half, f500, f250, f125, f62;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [5:0] bw;
  logic [4:0] coarse;
  int errors = 0;
  int total_checks = 0;
  int busy_cnt = 0;
  logic [33:0] bq [$];
  logic [33:0] rq [$];
  logic [33:0] cq [$];
  logic [7:0] cur [6];
  wire logic [18:0] trim_bus = {bw, coarse, f500, f250, f125, f62, buf_en, r_level, r_temp, r_half};

  rct_trim_regs #(.CAL_UNIT_CYCLES(UNIT)) dut (
    .CLOCK(clock), .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .CAL_START(cal_start), .CAL_BUSY(cal_busy), .CAL_DONE(cal_done),
    .FILTER_CAL_BANDWIDTH(bw), .CRYSTAL_COARSE_CAP(coarse),
    .CRYSTAL_FINE_CAP_500F(f500), .CRYSTAL_FINE_CAP_250F(f250),
    .CRYSTAL_FINE_CAP_125F(f125), .CRYSTAL_FINE_CAP_62F(f62),
    .LEVEL_PIN_BUFFER_EN(buf_en), .CONVERTER_ROUTE_LEVEL(r_level),
    .CONVERTER_ROUTE_TEMP(r_temp), .CONVERTER_ROUTE_SUPPLY_HALF(r_half)
  );

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic wrap_up;
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic timed_out;
    check(34'h0, 34'h1);
    wrap_up();
  endtask

  function automatic logic [11:0] ra(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  // The result monitor pairs each answer with the oldest note of the driver.
  always @(posedge clock) begin
    if (bvalid === 1'b1 && bready === 1'b1) begin
      if (bq.size() > 0) check({32'h0, bresp}, bq.pop_front());
      else check(34'h0, 34'h1);
    end
    if (rvalid === 1'b1 && rready === 1'b1) begin
      if (rq.size() > 0) check({rresp, rdata}, rq.pop_front());
      else check(34'h0, 34'h1);
    end
    if (cal_done === 1'b1) begin
      if (cq.size() > 0) check(34'(busy_cnt), cq.pop_front());
      else check(34'h0, 34'h1);
      busy_cnt = 0;
    end else if (cal_busy === 1'b1) begin
      busy_cnt++;
    end
  end

  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] exp);
    logic aw_done;
    logic w_done;
    int n;
    aw_done = 1'b0;
    w_done = 1'b0;
    n = 0;
    bq.push_back({32'h0, exp});
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (awvalid && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(aw_done && w_done) && n < 50);
    if (!(aw_done && w_done)) timed_out();
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (bvalid !== 1'b1 && n < 50);
    if (bvalid !== 1'b1) timed_out();
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [11:0] a, input logic [33:0] exp);
    int n;
    n = 0;
    rq.push_back(exp);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (arready !== 1'b1 && n < 50);
    if (arready !== 1'b1) timed_out();
    arvalid <= 1'b0;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (rvalid !== 1'b1 && n < 50);
    if (rvalid !== 1'b1) timed_out();
    // Ready comes late on purpose, so the answer must stand for a cycle.
    rready <= 1'b1;
    @(posedge clock);
    rready <= 1'b0;
  endtask

  // Expected drive comes from the bench's own copy of the register bytes.
  task automatic trims;
    logic [4:0] c;
    logic [2:0] r;
    c = (cur[2][4:0] > rct_pkg::COARSE_MAX) ? rct_pkg::COARSE_MAX : cur[2][4:0];
    r = (cur[5][2:0] == rct_pkg::SRC_LEVEL) ? 3'h4 : (cur[5][2:0] == rct_pkg::SRC_TEMP) ? 3'h2 :
        (cur[5][2:0] == rct_pkg::SRC_SUPPLY_HALF) ? 3'h1 : 3'h0;
    #1;
    check({15'h0, trim_bus}, {15'h0, cur[1][5:0], c, cur[3][3:0], cur[4][0], r});
  endtask

  task automatic wr(input int i, input logic [31:0] d);
    axi_write(ra(IDX[i]), d, 4'hF, rct_pkg::RESP_OKAY);
    cur[i] = d[7:0] & MASK[i];
    trims();
  endtask

  task automatic rd(input int i);
    axi_read(ra(IDX[i]), {rct_pkg::RESP_OKAY, 24'h0, cur[i]});
  endtask

  task automatic reset_checks;
    @(posedge clock);
    for (int i = 0; i < 6; i++) cur[i] = RSTV[i];
    trims();
    for (int i = 0; i < 6; i++) rd(i);
  endtask

  task automatic cal_run(input int d);
    int n;
    n = 0;
    wr(0, 32'(d));
    cq.push_back(34'(UNIT * (d + 4)));
    @(posedge clock);
    cal_start <= 1'b1;
    @(posedge clock);
    cal_start <= 1'b0;
    repeat (3) @(posedge clock);
    // A start while the timer runs must not stretch or restart it.
    cal_start <= 1'b1;
    @(posedge clock);
    cal_start <= 1'b0;
    do begin
      @(posedge clock);
      n++;
    end while (cal_done !== 1'b1 && n < 2000);
    if (cal_done !== 1'b1) timed_out();
  endtask

  initial begin
    void'($urandom(26));
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    reset_checks();
    for (int i = 0; i < 6; i++) begin
      wr(i, $urandom());
      rd(i);
    end
    for (int k = 0; k < 5; k++) wr(1, {26'h0, BWS[k]});
    for (int c = 0; c < 32; c++) wr(2, 32'(c));
    rd(2);
    for (int f = 0; f < 16; f++) wr(3, 32'(f));
    wr(4, 32'h00000000);
    wr(4, 32'hFFFFFFFE);
    wr(4, 32'h00000001);
    for (int s = 0; s < 8; s++) wr(5, 32'(s));
    axi_write(12'h240, 32'h000000FF, 4'hF, rct_pkg::RESP_SLVERR);
    axi_write(12'h231, 32'h00000003, 4'hF, rct_pkg::RESP_SLVERR);
    axi_write(ra(IDX[2]), 32'h00000005, 4'h0, rct_pkg::RESP_OKAY);
    trims();
    rd(2);
    axi_read(12'h240, {rct_pkg::RESP_SLVERR, 32'h0});
    axi_read(12'h224, {rct_pkg::RESP_SLVERR, 32'h0});
    axi_read(12'h231, {rct_pkg::RESP_SLVERR, 32'h0});
    cal_run(0);
    cal_run(15);
    cal_run(7);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    reset_checks();
    wrap_up();
  end
endmodule
`default_nettype wire
